// >>> logic/rpwm_pkg.sv
// ==========================================================================
// shared constants of the resonant pwm timing block
package rpwm_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_LIMIT_HIGH  = 8'h46;
    localparam logic [7:0]  IDX_LIMIT_LOW   = 8'h48;
    localparam logic [7:0]  IDX_RISE_C      = 8'h49;
    localparam logic [7:0]  IDX_BURST       = 8'h4A;
    localparam logic [7:0]  IDX_CONTROL     = 8'h50;
    localparam logic [7:0]  IDX_STATUS      = 8'h51;
    // reset values
    localparam logic [7:0]  RST_LIMIT_HIGH  = 8'h00;
    localparam logic [7:0]  RST_LIMIT_LOW   = 8'h00;
    localparam logic [7:0]  RST_RISE_C      = 8'h00;
    localparam logic [7:0]  RST_BURST       = 8'h00;
    localparam logic [7:0]  RST_CONTROL     = 8'h00;
    // field positions
    localparam int          LOW_NIB_MSB     = 7;
    localparam int          LOW_NIB_LSB     = 4;
    localparam int          BURST_EN_MSB    = 7;
    localparam int          BURST_EN_LSB    = 6;
    localparam int          BURST_OFS_MSB   = 5;
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          STAT_BRIDGE_OUTPUT_C_BIT   = 12;
    localparam int          STAT_BURST_BIT  = 13;
    // burst enable codes
    localparam logic [1:0]  BURST_NORMAL    = 2'h1;
    localparam logic [1:0]  BURST_ALWAYS    = 2'h3;
    // timing: one count of a setting, and the controller clock
    localparam int          STEP_PS         = 5000;
    localparam int          CLK_PERIOD_PS   = 10000;
    localparam logic [12:0] STEPS_PER_CLK   = 13'(CLK_PERIOD_PS / STEP_PS);
    // ahb codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
endpackage

// >>> logic/rpwm_edge_offset.sv
`timescale 1ns/100ps
// ==========================================================================
// places the output c rising edge around the cycle midpoint
module rpwm_edge_offset #(
    parameter int OFS_W = 8                   // width of the offset code
) (
    input  wire logic [12:0]      period_i,   // cycle length, 5 ns steps
    input  wire logic [OFS_W-1:0] code_i,     // signed offset code
    output logic      [12:0]      rise_o      // rise position, 5 ns steps
);
    // refuse widths the offset arithmetic cannot serve
    if (OFS_W != 8) begin : g_bad_width
        $error("rpwm_edge_offset: OFS_W must be 8");
    end

    logic [12:0] cycle_midpoint;              // half of the cycle
    logic [12:0] rise_offset_c;               // offset magnitude
    logic        lead;                        // edge before the midpoint

    // ======================================================================
    // signed offset to an absolute position, clamped into the cycle
    always_comb begin
        cycle_midpoint = {1'b0, period_i[12:1]};
        lead           = code_i[OFS_W-1];
        if (lead) begin
            rise_offset_c = 13'h0100 - {5'h00, code_i};
        end else begin
            rise_offset_c = {5'h00, code_i};
        end
        if (lead) begin
            if (rise_offset_c > cycle_midpoint) begin
                rise_o = 13'h0000;            // cannot lead the cycle start
            end else begin
                rise_o = cycle_midpoint - rise_offset_c;
            end
        end else begin
            if (cycle_midpoint + rise_offset_c >= period_i) begin
                rise_o = period_i;            // never rises this cycle
            end else begin
                rise_o = cycle_midpoint + rise_offset_c;
            end
        end
    end
endmodule

// >>> logic/rpwm_timing.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
// ==========================================================================
module rpwm_timing (
    input  wire logic        clock_i,         // 100 MHz controller clock
    input  wire logic        nrst_i,          // async reset, active low
    input  wire logic        hsel_i,          // ahb slave select
    input  wire logic [31:0] haddr_i,         // ahb address
    input  wire logic [1:0]  htrans_i,        // ahb transfer type
    input  wire logic        hwrite_i,        // ahb write
    input  wire logic [2:0]  hsize_i,         // ahb size
    input  wire logic        hready_i,        // ahb bus ready
    input  wire logic [31:0] hwdata_i,        // ahb write data
    output logic      [31:0] hrdata_o,        // ahb read data
    output logic             hreadyout_o,     // ahb slave ready
    output logic             hresp_o,         // ahb response
    input  wire logic [11:0] period_req_i,    // loop demand, 5 ns steps
    input  wire logic        soft_start_i,    // soft start phase active
    output logic             bridge_output_c_o, // output c drive
    output logic             burst_active_o   // burst mode engaged
);
    // ======================================================================
    // register storage
    logic [7:0]  limit_high;                  // upper limit byte
    logic [7:0]  limit_low;                   // nibble in 7..4
    logic [7:0]  rise_c;                      // output c rise code
    logic [7:0]  burst_ctl;                   // burst enable and offset
    logic [7:0]  control;                     // run enable
    logic [7:0]  next_limit_high;
    logic [7:0]  next_limit_low;
    logic [7:0]  next_rise_c;
    logic [7:0]  next_burst_ctl;
    logic [7:0]  next_control;
    // ahb data phase state
    logic        wr_pend;                     // write in data phase
    logic [7:0]  wr_idx;                      // its register index
    logic [31:0] rdata;                       // read data register
    logic        next_wr_pend;
    logic [7:0]  next_wr_idx;
    logic [31:0] next_rdata;
    // switching state
    logic [12:0] cyc_cnt;                     // position, 5 ns steps
    logic [12:0] period;                      // latched cycle length
    logic [12:0] rise_pos;                    // latched rise position
    logic        out_c;                       // output c register
    logic        burst;                       // burst engaged this cycle
    logic [12:0] next_cyc_cnt;
    logic [12:0] next_period;
    logic [12:0] next_rise_pos;
    logic        next_out_c;
    logic        next_burst;
    // derived values
    logic [11:0] cycle_limit;                 // full 12-bit limit
    logic [12:0] eff_period;                  // demand raised to the limit
    logic [12:0] new_rise;                    // rise for eff_period
    logic [12:0] threshold;                   // burst entry threshold
    logic        burst_allow;                 // burst permitted now
    logic        addr_ok;                     // valid address phase
    logic        cycle_end;                   // last clock of the cycle

    // ======================================================================
    // word address to register index
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    // ======================================================================
    // ahb slave: zero wait state, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata;
    assign addr_ok     = hsel_i && hready_i
                         && (htrans_i == rpwm_pkg::HTRANS_NONSEQ)
                         && (hsize_i == rpwm_pkg::HSIZE_WORD);

    // address phase decode, read data captured for the data phase
    always_comb begin
        next_wr_pend = addr_ok && hwrite_i;
        next_wr_idx  = reg_index(haddr_i);
        next_rdata   = rdata;
        if (addr_ok && !hwrite_i) begin
            unique case (reg_index(haddr_i))
                rpwm_pkg::IDX_LIMIT_HIGH: next_rdata = {24'h0, limit_high};
                rpwm_pkg::IDX_LIMIT_LOW:  next_rdata = {24'h000000, limit_low};
                rpwm_pkg::IDX_RISE_C:     next_rdata = {24'h000000, rise_c};
                rpwm_pkg::IDX_BURST:      next_rdata = {24'h000000, burst_ctl};
                rpwm_pkg::IDX_CONTROL:    next_rdata = {24'h000000, control};
                rpwm_pkg::IDX_STATUS: begin
                    next_rdata = {19'h00000, period};
                    next_rdata[rpwm_pkg::STAT_BRIDGE_OUTPUT_C_BIT]  = out_c;
                    next_rdata[rpwm_pkg::STAT_BURST_BIT] = burst;
                end
                default:                  next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
            rdata   <= 32'h00000000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_idx  <= next_wr_idx;
            rdata   <= next_rdata;
        end
    end

    // ======================================================================
    // register writes in the data phase; unmapped writes are dropped
    always_comb begin
        next_limit_high = limit_high;
        next_limit_low  = limit_low;
        next_rise_c     = rise_c;
        next_burst_ctl  = burst_ctl;
        next_control    = control;
        if (wr_pend) begin
            unique case (wr_idx)
                rpwm_pkg::IDX_LIMIT_HIGH: next_limit_high = hwdata_i[7:0];
                rpwm_pkg::IDX_LIMIT_LOW:  next_limit_low  = hwdata_i[7:0];
                rpwm_pkg::IDX_RISE_C:     next_rise_c     = hwdata_i[7:0];
                rpwm_pkg::IDX_BURST:      next_burst_ctl  = hwdata_i[7:0];
                rpwm_pkg::IDX_CONTROL:    next_control    = hwdata_i[7:0];
                default:                  next_control    = control;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            limit_high <= rpwm_pkg::RST_LIMIT_HIGH;
            limit_low  <= rpwm_pkg::RST_LIMIT_LOW;
            rise_c     <= rpwm_pkg::RST_RISE_C;
            burst_ctl  <= rpwm_pkg::RST_BURST;
            control    <= rpwm_pkg::RST_CONTROL;
        end else begin
            limit_high <= next_limit_high;
            limit_low  <= next_limit_low;
            rise_c     <= next_rise_c;
            burst_ctl  <= next_burst_ctl;
            control    <= next_control;
        end
    end

    // ======================================================================
    // limit, burst threshold and permission
    always_comb begin
        cycle_limit = {limit_high,
                       limit_low[rpwm_pkg::LOW_NIB_MSB:rpwm_pkg::LOW_NIB_LSB]};
        if (period_req_i < cycle_limit) begin
            eff_period = {1'b0, cycle_limit};
        end else begin
            eff_period = {1'b0, period_req_i};
        end
        if (eff_period < rpwm_pkg::STEPS_PER_CLK) begin
            eff_period = rpwm_pkg::STEPS_PER_CLK;
        end
        threshold = {1'b0, cycle_limit}
                  + {7'h00, burst_ctl[rpwm_pkg::BURST_OFS_MSB:0]};
        unique case (burst_ctl[rpwm_pkg::BURST_EN_MSB:rpwm_pkg::BURST_EN_LSB])
            rpwm_pkg::BURST_NORMAL: burst_allow = !soft_start_i;
            rpwm_pkg::BURST_ALWAYS: burst_allow = 1'b1;
            default:                burst_allow = 1'b0;
        endcase
    end

    rpwm_edge_offset #(
        .OFS_W    (8)
    ) i_rpwm_edge_offset (
        .period_i (eff_period),
        .code_i   (rise_c),
        .rise_o   (new_rise)
    );

    // ======================================================================
    // cycle counter, advancing two 5 ns steps per clock
    always_comb begin
        cycle_end     = (cyc_cnt + rpwm_pkg::STEPS_PER_CLK) >= period;
        next_cyc_cnt  = cyc_cnt + rpwm_pkg::STEPS_PER_CLK;
        next_period   = period;
        next_rise_pos = rise_pos;
        next_burst    = burst;
        if (!control[rpwm_pkg::CTRL_RUN_BIT]) begin
            next_cyc_cnt = 13'h0000;          // held idle, restart at zero
            next_period  = eff_period;
            next_rise_pos = new_rise;
            next_burst   = 1'b0;
        end else if (cycle_end) begin
            next_cyc_cnt  = 13'h0000;
            next_period   = eff_period;
            next_rise_pos = new_rise;
            next_burst    = burst_allow && ({1'b0, period_req_i} <= threshold);
        end
        next_out_c = control[rpwm_pkg::CTRL_RUN_BIT] && !next_burst
                     && (next_cyc_cnt >= next_rise_pos);
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cyc_cnt  <= 13'h0000;
            period   <= rpwm_pkg::STEPS_PER_CLK;
            rise_pos <= 13'h0000;
            out_c    <= 1'b0;
            burst    <= 1'b0;
        end else begin
            cyc_cnt  <= next_cyc_cnt;
            period   <= next_period;
            rise_pos <= next_rise_pos;
            out_c    <= next_out_c;
            burst    <= next_burst;
        end
    end

    assign bridge_output_c_o = out_c;
    assign burst_active_o    = burst;
endmodule

// >>> verification/rpwm_timing_properties.sv
`timescale 1ns/100ps
// ==========================================
// port checks of the timing block
module rpwm_timing_properties (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [2:0]  hsize_i,
    input wire logic        hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [11:0] period_req_i,
    input wire logic        soft_start_i,
    input wire logic        bridge_output_c_o,
    input wire logic        burst_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic        wr_q;   // write data phase due
    logic [7:0]  wa_q;   // its register index
    logic [7:0]  s_lo;   // shadow limit low
    logic [7:0]  s_hi;   // shadow limit high
    logic [7:0]  s_rc;   // shadow rise offset
    logic [7:0]  s_bc;   // shadow burst control
    logic [7:0]  s_ct;   // shadow control
    logic [7:0]  sv;     // value a read should return
    logic        sk;     // read value is known
    logic [12:0] st_cnt; // cycles since a setting changed
    logic [11:0] gap;    // cycles since output c rose
    wire  [12:0] lim = {1'b0, s_hi, s_lo[7:4]};
    wire  [12:0] thr = lim + {7'h00, s_bc[5:0]};
    wire         tk  = hsel_i && hready_i && htrans_i == 2'h2
                       && hsize_i == 3'h2;
    // ==========================================
    // expected read value of the addressed register
    always_comb begin
        sk = 1'b1;
        case (haddr_i[9:2])
            rpwm_pkg::IDX_LIMIT_LOW:  sv = s_lo;
            rpwm_pkg::IDX_LIMIT_HIGH: sv = s_hi;
            rpwm_pkg::IDX_RISE_C:     sv = s_rc;
            rpwm_pkg::IDX_BURST:      sv = s_bc;
            rpwm_pkg::IDX_CONTROL:    sv = s_ct;
            default:                  sv = 8'h00;
        endcase
        if (haddr_i[9:2] == rpwm_pkg::IDX_STATUS) sk = 1'b0;
    end
    // shadow registers and the two counters
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q   <= 1'b0;
            wa_q   <= 8'h00;
            s_lo   <= 8'h00;
            s_hi   <= 8'h00;
            s_rc   <= 8'h00;
            s_bc   <= 8'h00;
            s_ct   <= 8'h00;
            st_cnt <= 13'h0000;
            gap    <= 12'h000;
        end else begin
            wr_q <= tk && hwrite_i;
            wa_q <= haddr_i[9:2];
            if (wr_q && wa_q == rpwm_pkg::IDX_LIMIT_LOW) s_lo <= hwdata_i[7:0];
            if (wr_q && wa_q == rpwm_pkg::IDX_LIMIT_HIGH)
                s_hi <= hwdata_i[7:0];
            if (wr_q && wa_q == rpwm_pkg::IDX_RISE_C) s_rc <= hwdata_i[7:0];
            if (wr_q && wa_q == rpwm_pkg::IDX_BURST) s_bc <= hwdata_i[7:0];
            if (wr_q && wa_q == rpwm_pkg::IDX_CONTROL) s_ct <= hwdata_i[7:0];
            if (wr_q || $changed(soft_start_i) || $changed(period_req_i))
                st_cnt <= 13'h0000;
            else if (st_cnt != 13'h1FFF)
                st_cnt <= st_cnt + 13'h0001;
            if ($rose(bridge_output_c_o)) gap <= 12'h000;
            else if (gap != 12'hFFF) gap <= gap + 12'h001;
        end
    end
    // ==========================================
    // assertions
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    a_read_back: assert property (
        tk && !hwrite_i && sk |=> hrdata_o == {24'h0, $past(sv)})
        else $error("register read back wrong");
    a_period_floor: assert property (
        $rose(bridge_output_c_o) && st_cnt > 13'h1068
        |-> {gap, 1'b0} + 13'h0002 >= lim)
        else $error("switching period below limit");
    a_burst_off: assert property (
        st_cnt > 13'h0834 && s_ct[0] && (!s_bc[6]
        || (s_bc[7:6] == 2'h1 && soft_start_i)) |-> !burst_active_o)
        else $error("burst while disabled");
    a_burst_on: assert property (
        st_cnt > 13'h0834 && s_ct[0] && s_bc[7:6] == 2'h3
        && {1'b0, period_req_i} <= thr |-> burst_active_o)
        else $error("burst missing");
    a_burst_gate: assert property (
        st_cnt > 13'h0834 && s_ct[0] && {1'b0, period_req_i} > thr
        |-> !burst_active_o)
        else $error("burst above threshold");
    a_run_gate: assert property (
        !s_ct[0] && !$past(s_ct[0]) |-> !bridge_output_c_o)
        else $error("output c high while stopped");
    a_burst_mute: assert property (
        burst_active_o [*2] |-> !bridge_output_c_o)
        else $error("output c high in burst");
endmodule

// >>> verification/rpwm_timing_bench.sv
`timescale 1ns/100ps
// ==========================================
// self-checking bench of the timing block
module rpwm_timing_bench;
    logic        clock_i = 1'b0;       // 100 MHz clock
    logic        nrst_i = 1'b0;        // reset, active low
    logic        hsel_i = 1'b0;        // bus select
    logic [31:0] haddr_i = 32'h0;      // bus address
    logic [1:0]  htrans_i = 2'h0;      // bus transfer type
    logic        hwrite_i = 1'b0;      // bus direction
    logic [2:0]  hsize_i = 3'h2;       // whole word, byte only in the refused write
    logic [31:0] hwdata_i = 32'h0;     // bus write data
    logic [11:0] period_req_i = 12'h0; // requested cycle length
    logic        soft_start_i = 1'b0;  // soft start phase
    logic [31:0] hrdata_o;             // bus read data
    logic        hreadyout_o;          // slave ready, also hready
    logic        hresp_o;              // slave response
    logic        bridge_output_c_o;    // output c
    logic        burst_active_o;       // burst engaged
    int          failures = 0;         // mismatches
    int          checks = 0;           // comparisons
    int          seed = 15206;         // random seed
    int          cyc = 0;              // cycles run
    int          lo, hi, ex, a, b;     // measured and expected
    logic [31:0] q;                    // read data
    logic [7:0]  ixs [4] = '{rpwm_pkg::IDX_LIMIT_LOW,
        rpwm_pkg::IDX_LIMIT_HIGH, rpwm_pkg::IDX_RISE_C, rpwm_pkg::IDX_BURST};
    int          codes [5] = '{0, 1, 127, 128, 255}; // offset corners
    int          lhi [4] = '{16, 0, 1, 0};           // limit high cases
    int          llo [4] = '{154, 245, 0, 0};        // limit low cases
    rpwm_timing i_rpwm_timing (
        .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hready_i(hreadyout_o), .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .period_req_i(period_req_i), .soft_start_i(soft_start_i),
        .bridge_output_c_o(bridge_output_c_o),
        .burst_active_o(burst_active_o));
    // clock and hang guard
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            failures = failures + 1;
            end_sim();
        end
    end
    // ==========================================
    // tasks
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one single-word transfer, read data back in r
    task automatic xfer(input logic wr, input logic [7:0] ix,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clock_i);
        hsel_i   <= 1'b1;
        htrans_i <= rpwm_pkg::HTRANS_NONSEQ;
        haddr_i  <= {22'h0, ix, 2'h0};
        hwrite_i <= wr;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    // low then high time of one output c cycle, in clocks
    task automatic span(output int l, output int h);
        l = 0;
        h = 0;
        @(negedge clock_i);
        while (bridge_output_c_o !== 1'b1) @(negedge clock_i);
        while (bridge_output_c_o !== 1'b0) @(negedge clock_i);
        while (bridge_output_c_o === 1'b0) begin
            l++;
            @(negedge clock_i);
        end
        while (bridge_output_c_o === 1'b1) begin
            h++;
            @(negedge clock_i);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        foreach (ixs[i]) begin
            xfer(1'b0, ixs[i], 32'h0, q);
            check(q, 32'h0);
            ex = $random(seed);
            xfer(1'b1, ixs[i], ex, q);
            xfer(1'b0, ixs[i], 32'h0, q);
            check(q, {24'h0, ex[7:0]});
            xfer(1'b1, ixs[i], 32'h0, q);
        end
        xfer(1'b1, 8'h70, 32'hFF, q);
        xfer(1'b0, 8'h70, 32'h0, q);
        check(q, 32'h0);
        hsize_i <= 3'h0;
        xfer(1'b1, rpwm_pkg::IDX_RISE_C, 32'h55, q);
        hsize_i <= 3'h2;
        xfer(1'b0, rpwm_pkg::IDX_RISE_C, 32'h0, q);
        check(q, 32'h0); // byte write refused
        $display("register test done");
        xfer(1'b1, rpwm_pkg::IDX_CONTROL, 32'h1, q);
        period_req_i <= 12'h3E8;
        for (int i = 0; i < 8; i++) begin
            ex = (i < 5) ? codes[i] : ($random(seed) & 255);
            xfer(1'b1, rpwm_pkg::IDX_RISE_C, ex, q);
            span(lo, hi);
            span(lo, hi);
            ex = 500 + ((ex < 128) ? ex : ex - 256);
            check(lo, (ex + 1) / 2);
            check(lo + hi, 500);
        end
        $display("edge offset test done");
        xfer(1'b1, rpwm_pkg::IDX_RISE_C, 32'h0, q);
        period_req_i <= 12'h004;
        for (int i = 0; i < 6; i++) begin
            a = (i < 4) ? lhi[i] : ($random(seed) & 63);
            b = (i < 4) ? llo[i] : ($random(seed) & 255);
            xfer(1'b1, rpwm_pkg::IDX_LIMIT_HIGH, a, q);
            xfer(1'b1, rpwm_pkg::IDX_LIMIT_LOW, b, q);
            ex = (a * 16 + b / 16 < 4) ? 4 : a * 16 + b / 16;
            span(lo, hi);
            span(lo, hi);
            check(lo + hi, (ex + 1) / 2);
        end
        repeat (4300) @(posedge clock_i);
        $display("cycle limit test done");
        xfer(1'b1, rpwm_pkg::IDX_LIMIT_HIGH, 32'h06, q);
        xfer(1'b1, rpwm_pkg::IDX_LIMIT_LOW, 32'h40, q);
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, rpwm_pkg::IDX_BURST, {i[1:0], 6'h0A}, q);
            soft_start_i <= i[2];
            period_req_i <= i[3] ? 12'h06F : 12'h06E;
            repeat (2150) @(negedge clock_i);
            ex = !i[3] && (i[1:0] == 3 || (i[1:0] == 1 && !i[2]));
            check(burst_active_o, ex);
        end
        $display("burst test done");
        xfer(1'b1, rpwm_pkg::IDX_CONTROL, 32'h0, q);
        repeat (4) @(negedge clock_i);
        check(bridge_output_c_o, 1'b0); // run bit cleared
        check(burst_active_o, 1'b0); // run bit cleared
        xfer(1'b0, rpwm_pkg::IDX_STATUS, 32'h0, q);
        check(q, 32'h6F);
        $display("stop test done");
        end_sim();
    end
endmodule
bind rpwm_timing rpwm_timing_properties i_rpwm_timing_properties (
    .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .period_req_i(period_req_i), .soft_start_i(soft_start_i),
    .bridge_output_c_o(bridge_output_c_o),
    .burst_active_o(burst_active_o));
